// ===== hdl/fswdt_consts.svh
`ifndef FSWDT_CONSTS_SVH
`define FSWDT_CONSTS_SVH

// Prescaler division factors for the coarse and fine tick.
`define FSWDT_COARSE_DIV     16384
`define FSWDT_FINE_DIV       256

// Counter geometry: reload value fills the upper byte, low byte starts at 0.
`define FSWDT_CNT_W          16
`define FSWDT_RELOAD_W       8
`define FSWDT_CNT_MAX        16'hffff
`define FSWDT_LOW_ZERO       8'h00

// Reset values of the configuration: fine prescaler, reload of all ones.
`define FSWDT_RELOAD_RST     8'hff
`define FSWDT_COARSE_RST     1'b0

// Default interval after power-up, in microseconds, at the reference clock.
`define FSWDT_DEF_INTERVAL_US 6500
`define FSWDT_REF_CLK_MHZ     10
`define FSWDT_INTERVAL_GRAIN  100

// Core clock of this build.
`define FSWDT_CLK_PERIOD_NS   5

`endif

// ===== hdl/fswdt_pkg.sv
package fswdt_pkg;

    // Watchdog sequence states, one-hot.
    typedef enum logic [2:0] {
        FSWDT_RUN  = 3'b001,
        FSWDT_WARN = 3'b010,
        FSWDT_TRIP = 3'b100
    } fswdt_state_t;

endpackage

// ===== hdl/fswdt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "fswdt_consts.svh"

module fswdt_prescaler #(
    parameter int FINE_DIV   = `FSWDT_FINE_DIV,
    parameter int COARSE_DIV = `FSWDT_COARSE_DIV
) (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    input  wire logic clear_i,
    input  wire logic coarse_i,
    output logic      tick_o
);
    localparam int PW = $clog2(COARSE_DIV);

    logic [PW-1:0] div_count;
    logic [PW-1:0] limit;

    // The coarse factor must be the larger one and both must fit the counter.
    initial begin
        if (FINE_DIV < 2 || COARSE_DIV <= FINE_DIV) begin
            $error("fswdt_prescaler: unusable division factors");
        end
    end

    // Terminal count of the selected factor.
    assign limit  = coarse_i ? PW'(COARSE_DIV - 1) : PW'(FINE_DIV - 1);
    assign tick_o = run_i && !clear_i && (div_count >= limit);

    // Clear wins over counting so a service always restarts the phase.
    always_ff @(posedge core_clk_i) begin
        if (rst_i || clear_i) begin
            div_count <= '0;
        end else if (run_i) begin
            if (div_count >= limit) begin
                div_count <= '0;
            end else begin
                div_count <= div_count + PW'(1);
            end
        end
    end

endmodule

`default_nettype wire

// ===== hdl/fswdt_top.sv
// Operation
// - Every reset leaves the watchdog enabled and counting by itself.
// - Off and on commands stop and restart the watchdog on the next cycle.
// - Overflow raises a prewarning interrupt first, then a reset request.
// - Sixteen-bit counter advances on clock divided by 16384 or 256.
// - A service loads the counter from the programmable reload value.
// - A service reloads the counter and clears the prescaler together.
// - Reset configuration gives 6.5 ms interval at a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "fswdt_consts.svh"

module fswdt_top
    import fswdt_pkg::*;
#(
    parameter int CNT_W      = `FSWDT_CNT_W,
    parameter int RELOAD_W   = `FSWDT_RELOAD_W,
    parameter int FINE_DIV   = `FSWDT_FINE_DIV,
    parameter int COARSE_DIV = `FSWDT_COARSE_DIV
) (
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    input  wire logic                service_i,
    input  wire logic                watchdog_off_cmd_i,
    input  wire logic                watchdog_on_cmd_i,
    input  wire logic                config_load_i,
    input  wire logic [RELOAD_W-1:0] reload_value_field_i,
    input  wire logic                coarse_select_i,
    output logic                     enabled_o,
    output logic [CNT_W-1:0]         count_o,
    output logic                     prewarn_irq_o,
    output logic                     reset_req_o
);
    localparam int LOW_W = CNT_W - RELOAD_W;

    // Cycles of the default interval at the reference clock, for the check.
    // It uses the documented fine factor, so a shortened prescaler for
    // quick runs does not trip the check.
    localparam longint DEF_CYC =
        longint'(`FSWDT_FINE_DIV) * (longint'(1) << LOW_W)
        * ((longint'(1) << RELOAD_W) - longint'(`FSWDT_RELOAD_RST));

    fswdt_state_t           state;
    logic                   enabled;
    logic [CNT_W-1:0]       count;
    logic [RELOAD_W-1:0]    reload_value;
    logic                   coarse_sel;
    logic                   tick;
    logic                   svc_take;
    logic                   overflow;
    logic [CNT_W-1:0]       reload_word;

    // The reload value must leave room for a low part, and the default
    // configuration must land on the documented interval.
    initial begin
        if (CNT_W != `FSWDT_CNT_W || RELOAD_W >= CNT_W) begin
            $error("fswdt_top: counter geometry not supported");
        end
        if ((DEF_CYC / `FSWDT_REF_CLK_MHZ) / `FSWDT_INTERVAL_GRAIN !=
            `FSWDT_DEF_INTERVAL_US / `FSWDT_INTERVAL_GRAIN) begin
            $error("fswdt_top: default interval does not match");
        end
    end

    // Reload value sits in the upper part, low part restarts at zero.
    assign reload_word = {reload_value, LOW_W'(0)};

    // Service is ignored once the prewarning is out: a stuck core cannot
    // talk its way out of the pending reset by a late service.
    assign svc_take = service_i && (state == FSWDT_RUN);
    assign overflow = tick && (count == `FSWDT_CNT_MAX);

    // Prescaler runs only while enabled and before the trip.
    fswdt_prescaler #(
        .FINE_DIV   (FINE_DIV),
        .COARSE_DIV (COARSE_DIV)
    ) u_prescaler (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .run_i      (enabled && (state != FSWDT_TRIP)),
        .clear_i    (svc_take),
        .coarse_i   (coarse_sel),
        .tick_o     (tick)
    );

    // Enable flag: set by every reset, then owned by the two commands.
    // Should both commands arrive together, on wins to stay fail-safe.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            enabled <= 1'b1;
        end else if (watchdog_on_cmd_i) begin
            enabled <= 1'b1;
        end else if (watchdog_off_cmd_i) begin
            enabled <= 1'b0;
        end
    end

    // Configuration, loaded by the core through a strobe.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reload_value <= RELOAD_W'(`FSWDT_RELOAD_RST);
            coarse_sel   <= `FSWDT_COARSE_RST;
        end else if (config_load_i) begin
            reload_value <= reload_value_field_i;
            coarse_sel   <= coarse_select_i;
        end
    end

    // Counter: a service reloads, a tick increments, a wrap reloads too so
    // that the time to the reset request is one full interval.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            count <= {RELOAD_W'(`FSWDT_RELOAD_RST),
                      LOW_W'(`FSWDT_LOW_ZERO)};
        end else if (svc_take) begin
            count <= reload_word;
        end else if (overflow) begin
            count <= reload_word;
        end else if (tick) begin
            count <= count + CNT_W'(1);
        end
    end

    // Sequence: first overflow warns, second one trips the reset request.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= FSWDT_RUN;
        end else begin
            case (state)
                FSWDT_RUN: begin
                    if (overflow) begin
                        state <= FSWDT_WARN;
                    end
                end
                FSWDT_WARN: begin
                    if (overflow) begin
                        state <= FSWDT_TRIP;
                    end
                end
                FSWDT_TRIP: begin
                    state <= FSWDT_TRIP;
                end
                default: begin
                    state <= FSWDT_TRIP;
                end
            endcase
        end
    end

    // Outputs from flip-flops; the request holds until the system resets.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            prewarn_irq_o <= 1'b0;
            reset_req_o   <= 1'b0;
        end else begin
            prewarn_irq_o <= overflow && (state == FSWDT_RUN);
            reset_req_o   <= reset_req_o ||
                             (overflow && (state == FSWDT_WARN));
        end
    end

    assign enabled_o = enabled;
    assign count_o   = count;

    // Checks run on the core clock and stand down during reset.
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_enabled_after_reset;
        $fell(rst_i) |-> enabled_o;
    endproperty
    a_enabled_after_reset: assert property (p_enabled_after_reset)
        else $error("watchdog not enabled after reset");

    property p_off_cmd;
        watchdog_off_cmd_i && !watchdog_on_cmd_i |=> !enabled_o;
    endproperty
    a_off_cmd: assert property (p_off_cmd)
        else $error("off command not honoured");

    property p_on_cmd;
        watchdog_on_cmd_i |=> enabled_o;
    endproperty
    a_on_cmd: assert property (p_on_cmd)
        else $error("on command not honoured");

    property p_disabled_freezes;
        !enabled_o && !service_i |=> $stable(count_o);
    endproperty
    a_disabled_freezes: assert property (p_disabled_freezes)
        else $error("counter moved while disabled");

    property p_prewarn_first;
        $rose(reset_req_o) |-> $past(state) == FSWDT_WARN;
    endproperty
    a_prewarn_first: assert property (p_prewarn_first)
        else $error("reset request without prior prewarning");

    property p_overflow_warns;
        overflow && state == FSWDT_RUN |=> prewarn_irq_o ##1 !prewarn_irq_o;
    endproperty
    a_overflow_warns: assert property (p_overflow_warns)
        else $error("prewarning pulse missing after overflow");

    // Helper for the tick checks: cycles since the last tick or restart of
    // the prescaler, counted rather than unrolled since factors are large.
    localparam int GAP_W = $clog2(COARSE_DIV) + 1;
    localparam logic [GAP_W-1:0] FINE_GAP   = GAP_W'(FINE_DIV - 1);
    localparam logic [GAP_W-1:0] COARSE_GAP = GAP_W'(COARSE_DIV - 1);

    logic [GAP_W-1:0]       tick_gap;
    logic                   phase_known;
    logic                   after_svc;

    // Gap counter saturates so a long pause cannot wrap into a short gap.
    always_ff @(posedge core_clk_i) begin
        if (rst_i || tick || svc_take) begin
            tick_gap <= '0;
        end else if (tick_gap != '1) begin
            tick_gap <= tick_gap + GAP_W'(1);
        end
    end

    // A configuration load may shorten one interval, so it forgets the phase.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            phase_known <= 1'b1;
        end else if (config_load_i) begin
            phase_known <= 1'b0;
        end else if (tick || svc_take) begin
            phase_known <= 1'b1;
        end
    end

    // First interval after a service with the prescaler running throughout,
    // where the tick must land exactly on the selected factor.
    always_ff @(posedge core_clk_i) begin
        if (rst_i || config_load_i || !enabled) begin
            after_svc <= 1'b0;
        end else if (svc_take) begin
            after_svc <= 1'b1;
        end else if (tick) begin
            after_svc <= 1'b0;
        end
    end

    property p_fine_spacing;
        tick && !coarse_sel && phase_known |-> tick_gap >= FINE_GAP;
    endproperty
    a_fine_spacing: assert property (p_fine_spacing)
        else $error("prescaler ticks too close together");

    property p_service_reload;
        svc_take |=> count_o == $past(reload_word);
    endproperty
    a_service_reload: assert property (p_service_reload)
        else $error("service did not load the reload value");

    property p_svc_clears_prescaler;
        tick && after_svc
            |-> tick_gap == (coarse_sel ? COARSE_GAP : FINE_GAP);
    endproperty
    a_svc_clears_prescaler: assert property (p_svc_clears_prescaler)
        else $error("prescaler not cleared by service");

    property p_reset_config;
        $fell(rst_i) |-> reload_value == `FSWDT_RELOAD_RST && !coarse_sel;
    endproperty
    a_reset_config: assert property (p_reset_config)
        else $error("reset configuration wrong");

    property p_increment;
        tick && !svc_take && count != `FSWDT_CNT_MAX
            |=> count == $past(count) + CNT_W'(1);
    endproperty
    a_increment: assert property (p_increment)
        else $error("counter did not advance by one");

    c_service: cover property (svc_take ##1 tick);
    c_prewarn: cover property ($rose(prewarn_irq_o));
    c_trip:    cover property ($rose(reset_req_o));
    c_off_on:  cover property (watchdog_off_cmd_i ##[1:20] watchdog_on_cmd_i);

endmodule

`default_nettype wire

// ===== sim/fswdt_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module fswdt_core_model (
    input  wire logic       core_clk_i,
    input  wire logic [2:0] op_i,
    output logic            service_o,
    output logic            off_o,
    output logic            on_o,
    output logic            cfg_o
);
    // Each op becomes a one-cycle instruction pulse one edge later.
    // The core may be slow: the bench picks when each op is issued.
    always @(posedge core_clk_i) begin
        service_o <= (op_i == 3'h1);
        off_o     <= (op_i == 3'h2) || (op_i == 3'h5);
        on_o      <= (op_i == 3'h3) || (op_i == 3'h5);
        cfg_o     <= (op_i == 3'h4);
    end
endmodule

`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int FD = 4;
    localparam int CD = 16;
    typedef struct {int at; logic [16:0] v;} fswdt_exp_t;
    logic        core_clk_i = 1'b0;
    logic        rst_i      = 1'b1;
    logic [2:0]  op         = 3'h0;
    logic [7:0]  rld        = 8'hff;
    logic        crs        = 1'b0;
    logic        svc, off, on, cfg, en, pw, rq;
    logic        rq_d       = 1'b0;
    logic [15:0] cnt;
    logic [15:0] lf         = 16'h3567;
    int          cyc        = 0;
    int          error_cnt  = 0;
    int          check_count = 0;
    fswdt_exp_t  cnt_q[$];
    int          evt_q[$];

    // Clock at 200 MHz.
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    fswdt_core_model u_core (.core_clk_i(core_clk_i), .op_i(op),
        .service_o(svc), .off_o(off), .on_o(on), .cfg_o(cfg));

    // Short dividers keep each interval to about a thousand cycles.
    fswdt_top #(.FINE_DIV(FD), .COARSE_DIV(CD)) u_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .service_i(svc),
        .watchdog_off_cmd_i(off), .watchdog_on_cmd_i(on),
        .config_load_i(cfg), .reload_value_field_i(rld),
        .coarse_select_i(crs), .enabled_o(en), .count_o(cnt),
        .prewarn_irq_o(pw), .reset_req_o(rq));

    // Cycle count used to time every expected result.
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic cmp_val(input logic [16:0] e, input logic [16:0] a);
        check_count++;
        if (a !== e) begin
            error_cnt++;
            $display("unexpected %0t exp %h got %h", $time, e, a);
        end
    endtask

    task automatic cmp_cyc(input int e, input int a);
        check_count++;
        if (a != e) begin
            error_cnt++;
            $display("unexpected %0t exp %h got %h", $time, e, a);
        end
    endtask

    task automatic note(input int at, input logic [16:0] v);
        cnt_q.push_back('{at, v});
    endtask

    // The op is taken by the design two edges later; t marks the start.
    task automatic issue(input logic [2:0] o, output int t);
        @(posedge core_clk_i);
        t = cyc;
        op <= o;
        @(posedge core_clk_i);
        op <= 3'h0;
    endtask

    task automatic print_verdict;
        if (cnt_q.size() + evt_q.size() != 0) error_cnt++;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watch outputs on the falling edge, where they have settled.
    always @(negedge core_clk_i) begin
        if (cnt_q.size() > 0 && cnt_q[0].at == cyc)
            cmp_val(cnt_q.pop_front().v, {en, cnt});
        if (pw === 1'b1 || (rq === 1'b1 && rq_d !== 1'b1)) begin
            if (evt_q.size() > 0) cmp_cyc(evt_q.pop_front(), cyc);
            else cmp_cyc(-1, cyc);
        end
        rq_d = rq;
    end

    // A hang costs at most this many cycles before the verdict.
    initial begin
        repeat (20000) @(posedge core_clk_i);
        error_cnt++;
        print_verdict();
    end

    initial begin
        int t;
        int b;
        int d;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        note(cyc + 1, {1'b1, 16'hff00});
        // Service with reset configuration, then let it run out twice.
        issue(3'h1, t);
        b = t + 3;
        note(b, {1'b1, 16'hff00});
        note(b + FD, {1'b1, 16'hff01});
        note(b + 256 * FD, {1'b1, 16'hff00});
        evt_q.push_back(b + 256 * FD);
        evt_q.push_back(b + 512 * FD);
        repeat (1100) @(posedge core_clk_i);
        issue(3'h1, t);
        repeat (1100) @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        note(cyc + 1, {1'b1, 16'hff00});
        // Stop, restart and stop again; on and off together restart it.
        issue(3'h1, t);
        issue(3'h2, t);
        note(t + 3, {1'b0, 16'hff00});
        note(t + 23, {1'b0, 16'hff00});
        repeat (30) @(posedge core_clk_i);
        issue(3'h3, t);
        note(t + 3, {1'b1, 16'hff00});
        issue(3'h2, t);
        note(t + 3, {1'b0, 16'hff01});
        issue(3'h5, t);
        note(t + 3, {1'b1, 16'hff01});
        // Random reload values and prescaler choices, serviced mid-phase.
        for (int i = 0; i < 6; i++) begin
            lf = lfsr_next(lf);
            rld <= lf[7:0];
            crs <= lf[8];
            issue(3'h4, t);
            repeat (lf[1:0] + 1) @(posedge core_clk_i);
            issue(3'h1, t);
            b = t + 3;
            d = lf[8] ? CD : FD;
            note(b, {1'b1, lf[7:0], 8'h00});
            note(b + d - 1, {1'b1, lf[7:0], 8'h00});
            note(b + d, {1'b1, lf[7:0], 8'h01});
            repeat (CD + 4) @(posedge core_clk_i);
        end
        print_verdict();
    end
endmodule

`default_nettype wire
